/* File: pkg/tpm_pkg.sv */
package tpm_pkg;

  // ---------------------------------------------------------------------------
  // Path types and alarm numbering
  // ---------------------------------------------------------------------------

  // Tributary path type codes as carried by the path adaptation entity.
  localparam logic [7:0] TU11_TYPE = 8'h01;
  localparam logic [7:0] TU12_TYPE = 8'h02;
  localparam logic [7:0] TU2_TYPE  = 8'h03;
  localparam logic [7:0] TU3_TYPE  = 8'h04;

  // First alarm number of each path type.
  localparam int TU3_BASE  = 0;
  localparam int TU2_BASE  = 10;
  localparam int TU12_BASE = 19;
  localparam int TU11_BASE = 28;
  localparam int ALARM_W   = 37;

  // Position of each alarm within the nine-alarm lower-order group.
  localparam int LO_LOP = 0;
  localparam int LO_AIS = 1;
  localparam int LO_UNEQ = 2;
  localparam int LO_SLM = 3;
  localparam int LO_TIM = 4;
  localparam int LO_RDI = 5;
  localparam int LO_REI = 6;
  localparam int LO_SD  = 7;
  localparam int LO_SF  = 8;

  // Position within the ten-alarm TU-3 group.
  localparam int HO_LOM = 2;
  localparam int HO_TIM = 5;

  // Bit positions inside the overhead bytes (bit 1 is the MSB, bit 8 the LSB).
  localparam int G1_RDI_BIT = 3;
  localparam int V5_RDI_BIT = 0;
  localparam int V5_REI_BIT = 5;

  // Control code points: zero enables, one disables.
  localparam logic [7:0] CTRL_ENABLE = 8'h00;

  // ---------------------------------------------------------------------------
  // Interval and reset values
  // ---------------------------------------------------------------------------

  localparam int  CLK_HZ        = 20_000_000;
  localparam int  INTERVAL_MIN  = 15;
  localparam longint INTERVAL_CYC = longint'(INTERVAL_MIN) * 60 * CLK_HZ;
  localparam logic [7:0]  AIS_CTRL_RST = 8'h00;
  localparam logic [7:0]  TIM_CTRL_RST = 8'h00;
  localparam logic [15:0] THR_PTR_RST  = 16'h0000;

  // ---------------------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------------------

  // Per-cycle overhead and defect indications from the path terminator.
  typedef struct packed {
    logic       lop;
    logic       ais;
    logic       h4Bad;
    logic       uneq;
    logic       slm;
    logic       traceValid;
    logic [7:0] traceRx;
    logic [7:0] traceExp;
    logic [7:0] g1;
    logic [7:0] v5;
    logic       v5Valid;
    logic       g1Valid;
    logic [7:0] berExp;
  } tpm_ovh_s;

  // One-cycle event strobes for the performance counters.
  typedef struct packed {
    logic ptrInc;
    logic ptrDec;
    logic nearEs;
    logic nearSes;
    logic farEs;
    logic farSes;
    logic nearBbe;
    logic farBbe;
    logic nearUas;
    logic farUas;
  } tpm_evt_s;

  localparam int CNT_N = 10;

  // Management actions.
  typedef enum logic [1:0] {ACT_CREATE, ACT_DELETE, ACT_GET, ACT_SET} tpm_act_e;

  // Attribute selectors, numbered in table order.
  typedef enum logic [3:0] {
    AT_AIS_CTRL, AT_INST_ID, AT_LAST_IVL, AT_THR_PTR, AT_CNT0, AT_CNT1, AT_CNT2,
    AT_CNT3, AT_CNT4, AT_CNT5, AT_CNT6, AT_CNT7, AT_CNT8, AT_CNT9, AT_TIM_CTRL
  } tpm_attr_e;

  // A management request.
  typedef struct packed {
    logic       valid;
    tpm_act_e   act;
    tpm_attr_e  attr;
    logic [15:0] instId;
    logic [31:0] data;
  } tpm_req_s;

  // A management answer.
  typedef struct packed {
    logic        valid;
    logic        ok;
    logic [31:0] data;
  } tpm_rsp_s;

endpackage : tpm_pkg

/* File: hw/tpm_path_monitor.sv */
`timescale 1ns/1ps
// How it works
// - Mismatch plus enabled control inserts AIS.
// - AIS control is eight-bit read/write setting.
// - TU-3 reports alarms zero through nine.
// - TU-2 reports alarms ten through eighteen.
// - TU-12 reports alarms nineteen through twenty-seven.
// - TU-11 reports alarms twenty-eight through thirty-six.
// - Bad H4 raises TU-3 loss of multiframe.
// - TU-3 trace uses J1, others J2.
// - RDI from G1 bit5 or V5 bit8.
// - REI from G1 bits1-4 or V5 bit3.
// - Degrade/fail when BER reaches shared thresholds.
// - Read-only number of last finished interval.
// - Count pointer increments, 32 bits.
// - Count pointer decrements, 32 bits.
// - Count near-end errored and severe seconds.
// - Count far-end errored and severe seconds.
// - Count near and far background errors.
// - Count near and far unavailable seconds.
// - Monitor identifier equals path entity identifier.
// - Threshold set pointer written at creation.
// - Trace differs from expected raises mismatch.
// - Separate control enables mismatch monitoring.
module tpm_path_monitor
  import tpm_pkg::*;
#(
  parameter longint INTERVAL_CYCLES = INTERVAL_CYC
) (
  input  wire logic              sys_clk,
  input  wire logic              srst,
  input  wire logic [7:0]        pathType,
  input  wire logic [15:0]       pathEntityId,
  input  wire tpm_ovh_s          ovh,
  input  wire tpm_evt_s          evt,
  input  wire logic [7:0]        sdThreshold,
  input  wire logic [7:0]        sfThreshold,
  input  wire tpm_req_s          req,
  output tpm_rsp_s               rsp,
  output logic [ALARM_W-1:0]     alarms,
  output logic                   aisInsert,
  output logic                   created
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------

  logic [7:0]        aisCtrl_q;      // Insertion control, zero means insert.
  logic [7:0]        timCtrl_q;      // Mismatch monitoring control.
  logic [15:0]       thrPtr_q;       // Threshold data set pointer.
  logic [15:0]       instId_q;       // Identifier fixed at creation.
  logic              created_q;      // One instance per path at most.
  logic [7:0]        lastIvl_q;      // Number of the last finished interval.
  logic [63:0]       ivlCnt_q;       // Cycles into the current interval.
  logic [31:0]       curCnt_q [CNT_N]; // Counts of the running interval.
  logic [31:0]       histCnt_q[CNT_N]; // Counts of the finished interval.
  logic [CNT_N-1:0]  evtVec;         // Event strobes as a vector.
  logic              ivlEnd;         // Interval boundary in this cycle.
  logic [ALARM_W-1:0] alarms_d;      // Next alarm vector.
  logic              timRaw;         // Unfiltered trace mismatch.
  logic              timAlarm;       // Mismatch after the monitor control.
  logic              rdi;            // Remote defect.
  logic              rei;            // Remote error.
  logic              sd;             // Signal degrade.
  logic              sf;             // Signal fail.
  logic [8:0]        group;          // Nine-alarm lower-order group.
  logic              reqOk;          // Request accepted.
  logic [31:0]       rdData;         // Get answer data.

  // Event vector in counter index order.
  assign evtVec = {evt.farUas, evt.nearUas, evt.farBbe, evt.nearBbe, evt.farSes,
                   evt.farEs, evt.nearSes, evt.nearEs, evt.ptrDec, evt.ptrInc};

  // ---------------------------------------------------------------------------
  // Defect derivation
  // ---------------------------------------------------------------------------

  // Trace compare is only meaningful on a byte the terminator marked valid;
  // the caller presents J1 for TU-3 and J2 otherwise; no selection is made here.
  // Remote indications are ignored until their overhead byte is valid.
  always_comb begin
    timRaw   = ovh.traceValid && (ovh.traceRx != ovh.traceExp);
    timAlarm = timRaw && (timCtrl_q == CTRL_ENABLE);
    if (pathType == TU3_TYPE) begin
      rdi = ovh.g1Valid && ovh.g1[G1_RDI_BIT];
      rei = ovh.g1Valid && (ovh.g1[7:4] != 4'h0);
    end else begin
      rdi = ovh.v5Valid && ovh.v5[V5_RDI_BIT];
      rei = ovh.v5Valid && ovh.v5[V5_REI_BIT];
    end
    // Smaller exponent means a worse error ratio; BER >= 10^-X when exp <= X.
    sd = (ovh.berExp <= sdThreshold);
    sf = (ovh.berExp <= sfThreshold);
    group = {sf, sd, rei, rdi, timAlarm, ovh.slm, ovh.uneq, ovh.ais, ovh.lop};
  end

  // Map the defects onto the alarm number of the configured path type.
  always_comb begin
    alarms_d = '0;
    if (created_q) begin
      unique case (pathType)
        TU3_TYPE: begin
          alarms_d[TU3_BASE +: 10] = {sf, sd, rei, rdi, timAlarm, ovh.slm, ovh.uneq,
                                      ovh.h4Bad, ovh.ais, ovh.lop};
        end
        TU2_TYPE: begin
          alarms_d[TU2_BASE +: 9] = group;
        end
        TU12_TYPE: begin
          alarms_d[TU12_BASE +: 9] = group;
        end
        TU11_TYPE: begin
          alarms_d[TU11_BASE +: 9] = group;
        end
        default: begin
          alarms_d = '0;
        end
      endcase
    end
  end

  // Alarms and AIS insertion are registered so outputs come from flops.
  // This costs one cycle of latency, far below any management poll rate.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      alarms    <= '0;
      aisInsert <= 1'b0;
    end else begin
      alarms    <= alarms_d;
      aisInsert <= created_q && timAlarm && (aisCtrl_q == CTRL_ENABLE);
    end
  end

  // ---------------------------------------------------------------------------
  // Interval timing
  // ---------------------------------------------------------------------------

  assign ivlEnd = created_q && (ivlCnt_q == 64'(INTERVAL_CYCLES - 1));

  // The interval timer only runs while an instance exists.
  // A delete restarts numbering, so a fresh monitor begins at interval zero.
  always_ff @(posedge sys_clk) begin
    if (srst || !created_q) begin
      ivlCnt_q  <= '0;
      lastIvl_q <= 8'h00;
    end else if (ivlEnd) begin
      ivlCnt_q  <= '0;
      lastIvl_q <= lastIvl_q + 8'h01;
    end else begin
      ivlCnt_q  <= ivlCnt_q + 64'h1;
    end
  end

  // ---------------------------------------------------------------------------
  // Performance counters
  // ---------------------------------------------------------------------------

  // An event in the boundary cycle counts into the fresh interval so none is lost.
  // Counts wrap silently at 32 bits; a manager must read them often enough.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < CNT_N; i++) begin
      if (srst || !created_q) begin
        curCnt_q[i]  <= '0;
        histCnt_q[i] <= '0;
      end else if (ivlEnd) begin
        histCnt_q[i] <= curCnt_q[i];
        curCnt_q[i]  <= {31'h0, evtVec[i]};
      end else if (evtVec[i]) begin
        curCnt_q[i]  <= curCnt_q[i] + 32'h1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Management actions
  // ---------------------------------------------------------------------------

  // Requests address the monitor by identifier; create needs a free slot.
  // A refused request reads back zero so stale history cannot leak out.
  always_comb begin
    reqOk  = 1'b0;
    rdData = 32'h0;
    unique case (req.act)
      ACT_CREATE: reqOk = !created_q && (req.instId == pathEntityId);
      ACT_DELETE: reqOk = created_q && (req.instId == instId_q);
      ACT_GET: begin
        reqOk = created_q && (req.instId == instId_q);
        unique case (req.attr)
          AT_AIS_CTRL: rdData = {24'h0, aisCtrl_q};
          AT_INST_ID:  rdData = {16'h0, instId_q};
          AT_LAST_IVL: rdData = {24'h0, lastIvl_q};
          AT_THR_PTR:  rdData = {16'h0, thrPtr_q};
          AT_TIM_CTRL: rdData = {24'h0, timCtrl_q};
          default:     rdData = histCnt_q[4'(req.attr - AT_CNT0)];
        endcase
      end
      ACT_SET: begin
        // Only the three writable settings accept a set.
        reqOk = created_q && (req.instId == instId_q) &&
                (req.attr == AT_AIS_CTRL || req.attr == AT_THR_PTR ||
                 req.attr == AT_TIM_CTRL);
      end
    endcase
  end

  // Configuration and lifetime.
  // The identifier is latched at create and holds until the delete.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      created_q <= 1'b0;
      instId_q  <= 16'h0000;
      aisCtrl_q <= AIS_CTRL_RST;
      timCtrl_q <= TIM_CTRL_RST;
      thrPtr_q  <= THR_PTR_RST;
    end else if (req.valid && reqOk) begin
      unique case (req.act)
        ACT_CREATE: begin
          created_q <= 1'b1;
          instId_q  <= pathEntityId;
          thrPtr_q  <= req.data[15:0];
        end
        ACT_DELETE: begin
          created_q <= 1'b0;
        end
        ACT_SET: begin
          if (req.attr == AT_AIS_CTRL) begin
            aisCtrl_q <= req.data[7:0];
          end else if (req.attr == AT_TIM_CTRL) begin
            timCtrl_q <= req.data[7:0];
          end else begin
            thrPtr_q  <= req.data[15:0];
          end
        end
        ACT_GET: begin
          created_q <= created_q;
        end
      endcase
    end
  end

  // Answer one cycle after each request.
  // A pulse per request lets the manager issue requests back to back.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      rsp <= '0;
    end else begin
      rsp.valid <= req.valid;
      rsp.ok    <= req.valid && reqOk;
      rsp.data  <= (req.valid && reqOk) ? rdData : 32'h0;
    end
  end

  assign created = created_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  a_ais_insert: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && timAlarm && aisCtrl_q == CTRL_ENABLE) |=> aisInsert)
    else $error("AIS not inserted on mismatch.");

  a_ais_blocked: assert property (@(posedge sys_clk) disable iff (srst)
    (aisCtrl_q != CTRL_ENABLE) |=> !aisInsert)
    else $error("AIS inserted while disabled.");

  a_tu3_range: assert property (@(posedge sys_clk) disable iff (srst)
    $past(pathType) == TU3_TYPE |-> alarms[ALARM_W-1:10] == '0)
    else $error("TU-3 alarm outside its range.");

  a_tu2_range: assert property (@(posedge sys_clk) disable iff (srst)
    $past(pathType) == TU2_TYPE |-> (alarms[9:0] == '0 && alarms[ALARM_W-1:19] == '0))
    else $error("TU-2 alarm outside its range.");

  a_lom_raise: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && pathType == TU3_TYPE && ovh.h4Bad) |=> alarms[HO_LOM])
    else $error("Loss of multiframe not raised.");

  a_tim_gate: assert property (@(posedge sys_clk) disable iff (srst)
    (timCtrl_q != CTRL_ENABLE) |=> !aisInsert && !alarms[HO_TIM])
    else $error("Mismatch reported while not monitored.");

  a_count_step: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && !ivlEnd && evt.ptrInc) |=> curCnt_q[0] == $past(curCnt_q[0]) + 32'h1)
    else $error("Increment count did not step.");

  a_ivl_capture: assert property (@(posedge sys_clk) disable iff (srst)
    ivlEnd |=> (histCnt_q[2] == $past(curCnt_q[2]) &&
                lastIvl_q == $past(lastIvl_q) + 8'h01))
    else $error("Interval boundary not captured.");

  a_inst_id: assert property (@(posedge sys_clk) disable iff (srst)
    $rose(created_q) |-> instId_q == $past(pathEntityId))
    else $error("Identifier differs from path entity.");

  // Lower-order mapping, management rules and counter holds.
  a_tu12_range: assert property (@(posedge sys_clk) disable iff (srst)
    $past(pathType) == TU12_TYPE |-> (alarms[18:0] == '0 && alarms[ALARM_W-1:28] == '0))
    else $error("TU-12 alarm outside its range.");

  a_tu11_range: assert property (@(posedge sys_clk) disable iff (srst)
    $past(pathType) == TU11_TYPE |-> alarms[27:0] == '0)
    else $error("TU-11 alarm outside its range.");

  a_rdi_lower: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && pathType == TU12_TYPE && ovh.v5Valid && ovh.v5[V5_RDI_BIT])
      |=> alarms[TU12_BASE + LO_RDI])
    else $error("Lower-order RDI not raised.");

  a_fail_raise: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && pathType == TU12_TYPE && ovh.berExp <= sfThreshold)
      |=> alarms[TU12_BASE + LO_SF])
    else $error("Signal fail not raised.");

  a_trace_tim: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && pathType == TU2_TYPE && ovh.traceValid && ovh.traceRx != ovh.traceExp &&
     timCtrl_q == CTRL_ENABLE) |=> alarms[TU2_BASE + LO_TIM])
    else $error("Trace mismatch not raised.");

  a_ro_refused: assert property (@(posedge sys_clk) disable iff (srst)
    (req.valid && req.act == ACT_SET && req.attr == AT_LAST_IVL) |=> !rsp.ok)
    else $error("Read-only interval number accepted a set.");

  a_one_monitor: assert property (@(posedge sys_clk) disable iff (srst)
    (req.valid && req.act == ACT_CREATE && created_q) |=> !rsp.ok)
    else $error("Second monitor accepted on one path.");

  a_delete_frees: assert property (@(posedge sys_clk) disable iff (srst)
    (req.valid && req.act == ACT_DELETE && reqOk) |=> !created_q)
    else $error("Delete left the monitor in place.");

  a_thr_create: assert property (@(posedge sys_clk) disable iff (srst)
    (req.valid && req.act == ACT_CREATE && reqOk) |=> thrPtr_q == $past(req.data[15:0]))
    else $error("Threshold pointer not taken at create.");

  a_ais_write: assert property (@(posedge sys_clk) disable iff (srst)
    (req.valid && req.act == ACT_SET && req.attr == AT_AIS_CTRL && reqOk)
      |=> aisCtrl_q == $past(req.data[7:0]))
    else $error("Insertion control not written.");

  a_count_hold: assert property (@(posedge sys_clk) disable iff (srst)
    (created_q && !ivlEnd && !evt.ptrDec) |=> curCnt_q[1] == $past(curCnt_q[1]))
    else $error("Decrement count moved without an event.");

endmodule : tpm_path_monitor

/* File: sim/tpm_far_end_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Far-end path equipment model
// -----------------------------------------------------------------------------
module tpm_far_end_model
  import tpm_pkg::*;
(
  input  wire logic     sys_clk,
  input  wire logic     srst,
  input  wire tpm_ovh_s ovhCmd,
  input  wire tpm_evt_s evtCmd,
  output tpm_ovh_s      ovh,
  output tpm_evt_s      evt
);
  // Overhead lands one cycle after it is asked for, as a frame aligner would deliver it.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ovh <= '0;
    end else begin
      ovh <= ovhCmd;
    end
  end

  // Events are one-cycle pulses; a request held for n cycles gives n pulses.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      evt <= '0;
    end else begin
      evt <= evtCmd;
    end
  end
endmodule : tpm_far_end_model

/* File: sim/tb.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Bench top
// -----------------------------------------------------------------------------
module tb;
  import tpm_pkg::*;
  localparam longint      IVL    = 40;       // Short interval keeps the run brief.
  localparam logic [15:0] ENT_ID = 16'h0A5C; // Path entity id used throughout.
  logic                   sys_clk;
  logic                   srst;
  logic [7:0]             pathType;
  logic [7:0]             sdThreshold;
  logic [7:0]             sfThreshold;
  tpm_ovh_s               ovhCmd;
  tpm_ovh_s               ovh;
  tpm_evt_s               evtCmd;
  tpm_evt_s               evt;
  tpm_req_s               req;
  tpm_rsp_s               rsp;
  logic [ALARM_W-1:0]     alarms;
  logic                   aisInsert;
  logic                   created;
  logic [7:0]             ivlSeen;
  int                     fails;
  int                     samplesChecked;
  int                     cycles;

  tpm_far_end_model far_u (.sys_clk(sys_clk), .srst(srst), .ovhCmd(ovhCmd), .evtCmd(evtCmd),
                           .ovh(ovh), .evt(evt));
  tpm_path_monitor #(.INTERVAL_CYCLES(IVL)) dut_u (.sys_clk(sys_clk), .srst(srst),
    .pathType(pathType), .pathEntityId(ENT_ID), .ovh(ovh), .evt(evt),
    .sdThreshold(sdThreshold), .sfThreshold(sfThreshold), .req(req), .rsp(rsp),
    .alarms(alarms), .aisInsert(aisInsert), .created(created));

  // ---------------------------------------------------------------------------
  // Clock, timeout and verdict
  // ---------------------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // A hang is cut short well beyond the expected few hundred cycles.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      close_out();
    end
  end

  task automatic close_out();
    if (fails == 0 && samplesChecked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out

  // ---------------------------------------------------------------------------
  // Compare and access tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [36:0] exp, input logic [36:0] got);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk

  // Data is only meaningful on a get or a refusal, so only those compare it.
  task automatic chkRsp(input bit isGet, input logic expOk, input logic [31:0] expData);
    samplesChecked++;
    if (rsp.valid !== 1'b1 || rsp.ok !== expOk || ((isGet || !expOk) && rsp.data !== expData)) begin
      fails++;
      $display("unexpected answer: expected %b %h, seen %b %b %h", expOk, expData, rsp.valid,
               rsp.ok, rsp.data);
    end
  endtask : chkRsp

  // One request; its answer is launched by the edge that takes it and stands one cycle.
  task automatic mgmt(input tpm_act_e a, input tpm_attr_e at, input logic [15:0] id,
                      input logic [31:0] d);
    @(posedge sys_clk);
    req <= '{valid: 1'b1, act: a, attr: at, instId: id, data: d};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    #1;
  endtask : mgmt

  task automatic xfer(input tpm_act_e a, input tpm_attr_e at, input logic [15:0] id,
                      input logic [31:0] d, input logic expOk, input logic [31:0] expData);
    mgmt(a, at, id, d);
    chkRsp(a == ACT_GET, expOk, expData);
  endtask : xfer

  // Clean overhead, or one defect k: 0 lop .. 9 fail, in the TU-3 alarm order.
  function automatic tpm_ovh_s mk(input int k, input bit ho);
    tpm_ovh_s o;
    o = '0;
    o.traceValid = 1'b1;
    o.traceRx = 8'h3C;
    o.traceExp = 8'h3C;
    o.v5Valid = 1'b1;
    o.g1Valid = 1'b1;
    o.berExp = 8'h0F;
    case (k)
      0: o.lop = 1'b1;
      1: o.ais = 1'b1;
      2: o.h4Bad = 1'b1;
      3: o.uneq = 1'b1;
      4: o.slm = 1'b1;
      5: o.traceRx = 8'hC3;
      6: if (ho) o.g1[3] = 1'b1; else o.v5[0] = 1'b1;
      7: if (ho) o.g1[5] = 1'b1; else o.v5[5] = 1'b1;
      8: o.berExp = 8'h05;
      9: o.berExp = 8'h03;
      default: ;
    endcase
    return o;
  endfunction : mk

  // Lower-order paths have no multiframe alarm; a fail ratio also exceeds degrade.
  function automatic logic [36:0] expMask(input int k, input int base, input bit ho);
    logic [36:0] m;
    m = '0;
    if (ho) m[k] = 1'b1;
    else if (k != 2) m[base + ((k < 2) ? k : k - 1)] = 1'b1;
    if (k == 9) m[base + (ho ? 8 : 7)] = 1'b1;
    return m;
  endfunction : expMask

  task automatic alarmSweep(input int base, input bit ho);
    for (int k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      ovhCmd <= mk(k, ho);
      repeat (3) @(posedge sys_clk);
      #1;
      chk("alarms", expMask(k, base, ho), alarms);
      chk("aisInsert", k == 5, aisInsert);
    end
    @(posedge sys_clk);
    ovhCmd <= mk(-1, ho);
  endtask : alarmSweep

  task automatic restart(input logic [7:0] t, input int n);
    @(posedge sys_clk);
    srst <= 1'b1;
    pathType <= t;
    ovhCmd <= mk(-1, t == TU3_TYPE);
    repeat (n) @(posedge sys_clk);
    srst <= 1'b0;
    xfer(ACT_CREATE, AT_INST_ID, ENT_ID, 32'h0000_1234, 1'b1, '0);
  endtask : restart

  // Polls the finished-interval number until it moves on.
  task automatic waitIvl();
    logic [7:0] prev;
    prev = ivlSeen;
    for (int i = 0; i < 40 && ivlSeen === prev; i++) begin
      mgmt(ACT_GET, AT_LAST_IVL, ENT_ID, '0);
      ivlSeen = rsp.data[7:0];
    end
  endtask : waitIvl

  // Counter k gets k+1 pulses from one ten-cycle burst, away from any boundary.
  task automatic countPass(input bit fire);
    logic [7:0]  prev;
    logic [9:0]  b;
    waitIvl();
    prev = ivlSeen;
    for (int j = 0; j < 10 && fire; j++) begin
      for (int k = 0; k < CNT_N; k++) b[CNT_N-1-k] = (k >= j);
      @(posedge sys_clk);
      evtCmd <= tpm_evt_s'(b);
    end
    @(posedge sys_clk);
    evtCmd <= '0;
    waitIvl();
    chk("last interval", prev + 8'h01, ivlSeen);
    for (int k = 0; k < CNT_N; k++) begin
      xfer(ACT_GET, tpm_attr_e'(4 + k), ENT_ID, '0, 1'b1, fire ? k + 1 : 0);
    end
  endtask : countPass

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    srst = 1'b1;
    pathType = TU3_TYPE;
    sdThreshold = 8'h06;
    sfThreshold = 8'h03;
    ovhCmd = mk(-1, 1'b1);
    evtCmd = '0;
    req = '0;
    repeat (10) @(posedge sys_clk);
    srst <= 1'b0;
    #1;
    chk("created", 1'b0, created);
    chk("alarms", '0, alarms);
    xfer(ACT_GET, AT_LAST_IVL, ENT_ID, '0, 1'b0, '0);
    xfer(ACT_CREATE, AT_INST_ID, 16'h0001, 32'h0000_1234, 1'b0, '0);
    xfer(ACT_CREATE, AT_INST_ID, ENT_ID, 32'h0000_1234, 1'b1, '0);
    chk("created", 1'b1, created);
    xfer(ACT_CREATE, AT_INST_ID, ENT_ID, 32'h0000_1234, 1'b0, '0);
    xfer(ACT_GET, AT_INST_ID, ENT_ID, '0, 1'b1, ENT_ID);
    xfer(ACT_GET, AT_THR_PTR, ENT_ID, '0, 1'b1, 32'h0000_1234);
    xfer(ACT_GET, AT_AIS_CTRL, ENT_ID, '0, 1'b1, '0);
    xfer(ACT_SET, AT_AIS_CTRL, ENT_ID, 32'h0000_00A5, 1'b1, '0);
    xfer(ACT_GET, AT_AIS_CTRL, ENT_ID, '0, 1'b1, 32'h0000_00A5);
    xfer(ACT_SET, AT_LAST_IVL, ENT_ID, 32'h0000_0001, 1'b0, '0);
    xfer(ACT_SET, AT_CNT0, ENT_ID, 32'h0000_0001, 1'b0, '0);
    xfer(ACT_GET, AT_INST_ID, 16'h0001, '0, 1'b0, '0);
    xfer(ACT_SET, AT_THR_PTR, ENT_ID, 32'h0000_BEEF, 1'b1, '0);
    xfer(ACT_GET, AT_THR_PTR, ENT_ID, '0, 1'b1, 32'h0000_BEEF);
    xfer(ACT_SET, AT_AIS_CTRL, ENT_ID, '0, 1'b1, '0);
    alarmSweep(TU3_BASE, 1'b1);
    // Insertion disabled: the alarm stays, the insertion goes.
    xfer(ACT_SET, AT_AIS_CTRL, ENT_ID, 32'h0000_0001, 1'b1, '0);
    ovhCmd <= mk(5, 1'b1);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("alarms", 37'h20, alarms);
    chk("aisInsert", 1'b0, aisInsert);
    xfer(ACT_SET, AT_TIM_CTRL, ENT_ID, 32'h0000_0001, 1'b1, '0);
    xfer(ACT_GET, AT_TIM_CTRL, ENT_ID, '0, 1'b1, 32'h0000_0001);
    repeat (2) @(posedge sys_clk);
    #1;
    chk("alarms", '0, alarms);
    ovhCmd <= mk(-1, 1'b1);
    mgmt(ACT_GET, AT_LAST_IVL, ENT_ID, '0);
    ivlSeen = rsp.data[7:0];
    countPass(1'b1);
    countPass(1'b0);
    xfer(ACT_DELETE, AT_INST_ID, 16'h0001, '0, 1'b0, '0);
    xfer(ACT_DELETE, AT_INST_ID, ENT_ID, '0, 1'b1, '0);
    chk("created", 1'b0, created);
    xfer(ACT_GET, AT_INST_ID, ENT_ID, '0, 1'b0, '0);
    restart(TU2_TYPE, 2);
    alarmSweep(TU2_BASE, 1'b0);
    restart(TU12_TYPE, 2);
    alarmSweep(TU12_BASE, 1'b0);
    restart(TU11_TYPE, 2);
    alarmSweep(TU11_BASE, 1'b0);
    close_out();
  end
endmodule : tb
